// ### src/usel_pkg.sv
// Shared constants for the serial port status and event logic
package usel_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] USEL_STATUS_OFF  = 4'h0;
  localparam logic [3:0] USEL_CONTROL_OFF = 4'h4;

  // Status register layout
  localparam int USEL_BIT_TX_SVC    = 0;
  localparam int USEL_BIT_RX_SVC    = 1;
  localparam int USEL_BIT_RX_IDLE   = 2;
  localparam int USEL_BIT_BRK_BEGIN = 3;
  localparam int USEL_BIT_BRK_END   = 4;
  localparam int USEL_BIT_FIFO_ERR  = 5;

  // Control register layout
  localparam int USEL_BIT_TX_IE = 0;
  localparam int USEL_BIT_RX_IE = 1;

  localparam logic [7:0] USEL_STATUS_RESET  = 8'h00;
  localparam logic [1:0] USEL_CONTROL_RESET = 2'h0;

  // FIFO thresholds
  localparam logic [3:0] USEL_TX_SVC_MAX = 4'h4;
  localparam logic [3:0] USEL_RX_SVC_SET = 4'h8;
  localparam logic [3:0] USEL_RX_EMPTY   = 4'h0;

  // Frame periods of silence before idle is reported
  localparam logic [1:0] USEL_IDLE_FRAMES = 2'h3;

  // AXI response codes
  localparam logic [1:0] USEL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] USEL_RESP_SLVERR = 2'h2;

  // Register selector codes
  localparam logic [1:0] USEL_SEL_STATUS  = 2'h0;
  localparam logic [1:0] USEL_SEL_CONTROL = 2'h1;
  localparam logic [1:0] USEL_SEL_NONE    = 2'h2;

  // Break interlock states
  typedef enum logic [1:0] {
    USEL_BRK_OPEN   = 2'b01,
    USEL_BRK_LOCKED = 2'b10
  } usel_brk_type;

endpackage

// ### src/usel_rx_sync.sv
// Receive pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
`default_nettype none
module usel_rx_sync
  import usel_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output var  logic level_out
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } usel_sync_type;

  usel_sync_type s;
  usel_sync_type next_s;

  always_comb begin
    next_s = s;
    next_s.stage = {s.stage[1:0], pin_in};
    // Only stages two and three are compared; stage one may be metastable
    if (s.stage[1] == s.stage[2]) begin
      next_s.level = s.stage[2];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{stage: 3'h7, level: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.level;

endmodule // usel_rx_sync
`default_nettype wire

// ### src/usel_idle_timer.sv
// Counts silent frame periods and flags receiver idle
`timescale 1ns/1ps
`default_nettype none
module usel_idle_timer
  import usel_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic armed_in,
  input  wire logic frame_done_in,
  input  wire logic frame_tick_in,
  output var  logic idle_pulse_out
);

  typedef struct packed {
    logic [1:0] count;
    logic       pulse;
  } usel_idle_type;

  usel_idle_type s;
  usel_idle_type next_s;

  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    if (!armed_in || frame_done_in) begin
      next_s.count = 2'h0;
    end else if (frame_tick_in && s.count != USEL_IDLE_FRAMES) begin
      next_s.count = s.count + 2'h1;
      // Fires once per silent stretch so a cleared bit is not re-set
      next_s.pulse = (s.count + 2'h1) == USEL_IDLE_FRAMES;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{count: 2'h0, pulse: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign idle_pulse_out = s.pulse;

endmodule // usel_idle_timer
`default_nettype wire

// ### src/usel_top.sv
// Serial port status register, service requests and break detection
//
// Functional notes
// - Interrupt request tracks its status bit exactly
// - Sticky bits: hardware sets, write one clears
// - Flag writes have no effect
// - Transmit flag set at four or fewer
// - Transmit flag drives DMA and gated interrupt
// - Receive flag sets at eight entries
// - Receive flag clears below eight entries
// - Receive flag drives DMA and gated interrupt
// - Idle after three silent frames, nonempty
// - Idle interrupt gated by receive enable
// - Null frame with framing error begins break
// - Break: interrupt, store one null, discard rest
// - Begin re-arms only after end or disable
// - End of break on rising receive pin
// - End of break interrupts, reopens FIFO storage
// - End re-arms only after another begin
// - FIFO error flag interrupts, blocks receive DMA
`timescale 1ns/1ps
`default_nettype none
module usel_top
  import usel_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite slave
  input  wire logic [3:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output var  logic        awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output var  logic        wready_out,
  output var  logic [1:0]  bresp_out,
  output var  logic        bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [3:0]  araddr_in,
  input  wire logic        arvalid_in,
  output var  logic        arready_out,
  output var  logic [31:0] rdata_out,
  output var  logic [1:0]  rresp_out,
  output var  logic        rvalid_out,
  input  wire logic        rready_in,
  // Port status from the datapath
  input  wire logic [3:0]  tx_fifo_level_in,
  input  wire logic [3:0]  rx_fifo_level_in,
  input  wire logic        transmitter_enable_in,
  input  wire logic        receiver_enable_in,
  input  wire logic        rx_pin_in,
  input  wire logic        frame_done_in,
  input  wire logic        frame_null_in,
  input  wire logic        frame_framing_err_in,
  input  wire logic        frame_tick_in,
  input  wire logic        rx_tail_error_in,
  // Requests
  output var  logic        tx_dma_req_out,
  output var  logic        rx_dma_req_out,
  output var  logic        irq_out,
  output var  logic        frame_store_out
);

  typedef struct packed {
    logic         aw_held;
    logic [3:0]   aw_addr;
    logic         w_held;
    logic [7:0]   w_data;
    logic         w_low;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [31:0]  rdata;
    logic         tx_flag;
    logic         rx_flag;
    logic         rx_idle;
    logic         brk_begin;
    logic         brk_end;
    logic         fifo_err;
    logic         tx_ie;
    logic         rx_ie;
    usel_brk_type brk;
    logic         line_prev;
    logic         tx_dma;
    logic         rx_dma;
    logic         irq;
    logic         store;
  } usel_state_type;

  usel_state_type s;
  usel_state_type next_s;

  logic [1:0] rst_sync;
  logic       rst_n;
  logic       line_level;
  logic       idle_pulse;
  logic       do_write;
  logic [7:0] stat_w1c;
  logic       null_fe;
  logic       line_rise;

  function automatic logic [1:0] reg_sel(input logic [3:0] addr);
    unique case (addr)
      USEL_STATUS_OFF:  reg_sel = USEL_SEL_STATUS;
      USEL_CONTROL_OFF: reg_sel = USEL_SEL_CONTROL;
      default:          reg_sel = USEL_SEL_NONE;
    endcase
  endfunction

  // Reset is released through two flops to avoid recovery hazards
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  usel_rx_sync u_rx_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n),
    .pin_in    (rx_pin_in),
    .level_out (line_level)
  );

  usel_idle_timer u_idle_timer (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n),
    .armed_in       (receiver_enable_in && rx_fifo_level_in != USEL_RX_EMPTY),
    .frame_done_in  (frame_done_in),
    .frame_tick_in  (frame_tick_in),
    .idle_pulse_out (idle_pulse)
  );

  assign do_write  = s.aw_held && s.w_held && !s.bvalid;
  assign null_fe   = frame_done_in && frame_null_in && frame_framing_err_in && receiver_enable_in;
  assign line_rise = line_level && !s.line_prev;

  always_comb begin
    next_s = s;
    stat_w1c = 8'h00;

    // Write address and data are taken independently, in either order
    if (awvalid_in && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr_in;
    end
    if (wvalid_in && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata_in[7:0];
      next_s.w_low  = wstrb_in[0];
    end
    if (s.bvalid && bready_in) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = USEL_RESP_OKAY;
      unique case (reg_sel(s.aw_addr))
        USEL_SEL_STATUS: begin
          if (s.w_low) begin
            stat_w1c = s.w_data;
          end
        end
        USEL_SEL_CONTROL: begin
          if (s.w_low) begin
            next_s.tx_ie = s.w_data[USEL_BIT_TX_IE];
            next_s.rx_ie = s.w_data[USEL_BIT_RX_IE];
          end
        end
        default: begin
          next_s.bresp = USEL_RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready  = !next_s.w_held;

    // Read answers one cycle after the address is taken
    if (s.rvalid && rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid_in && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = USEL_RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      unique case (reg_sel(araddr_in))
        USEL_SEL_STATUS: begin
          next_s.rdata[USEL_BIT_TX_SVC]    = s.tx_flag;
          next_s.rdata[USEL_BIT_RX_SVC]    = s.rx_flag;
          next_s.rdata[USEL_BIT_RX_IDLE]   = s.rx_idle;
          next_s.rdata[USEL_BIT_BRK_BEGIN] = s.brk_begin;
          next_s.rdata[USEL_BIT_BRK_END]   = s.brk_end;
          next_s.rdata[USEL_BIT_FIFO_ERR]  = s.fifo_err;
        end
        USEL_SEL_CONTROL: begin
          next_s.rdata[USEL_BIT_TX_IE] = s.tx_ie;
          next_s.rdata[USEL_BIT_RX_IE] = s.rx_ie;
        end
        default: begin
          next_s.rresp = USEL_RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Flags follow hardware only; status writes never reach them
    next_s.tx_flag = transmitter_enable_in && tx_fifo_level_in <= USEL_TX_SVC_MAX;
    // Fixed thresholds chosen inside the tolerated window
    next_s.rx_flag = receiver_enable_in && rx_fifo_level_in >= USEL_RX_SVC_SET;
    next_s.fifo_err = rx_tail_error_in;

    // Sticky bits: a set in the same cycle as a clear wins
    next_s.rx_idle   = (s.rx_idle   && !stat_w1c[USEL_BIT_RX_IDLE]) || idle_pulse;
    next_s.brk_begin = s.brk_begin && !stat_w1c[USEL_BIT_BRK_BEGIN];
    next_s.brk_end   = s.brk_end   && !stat_w1c[USEL_BIT_BRK_END];

    next_s.line_prev = line_level;
    next_s.store     = frame_done_in && receiver_enable_in;

    unique case (s.brk)
      USEL_BRK_OPEN: begin
        if (null_fe) begin
          next_s.brk       = USEL_BRK_LOCKED;
          next_s.brk_begin = 1'b1;
        end
      end
      USEL_BRK_LOCKED: begin
        if (null_fe) begin
          next_s.store = 1'b0;
        end
        if (!receiver_enable_in) begin
          next_s.brk = USEL_BRK_OPEN;
        end else if (line_rise) begin
          next_s.brk     = USEL_BRK_OPEN;
          next_s.brk_end = 1'b1;
        end
      end
      default: begin
        next_s.brk = USEL_BRK_OPEN;
      end
    endcase

    // Requests use next values so they change with their bits
    next_s.tx_dma = next_s.tx_flag;
    next_s.rx_dma = next_s.rx_flag && !next_s.fifo_err;
    next_s.irq    = (next_s.tx_flag && next_s.tx_ie)
                 || (next_s.rx_flag && next_s.rx_ie)
                 || (next_s.rx_idle && next_s.rx_ie)
                 || next_s.brk_begin || next_s.brk_end || next_s.fifo_err;
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{aw_held: 1'b0, aw_addr: 4'h0, w_held: 1'b0, w_data: 8'h00, w_low: 1'b0,
             awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: USEL_RESP_OKAY,
             arready: 1'b1, rvalid: 1'b0, rresp: USEL_RESP_OKAY, rdata: 32'h0000_0000,
             tx_flag: USEL_STATUS_RESET[USEL_BIT_TX_SVC], rx_flag: USEL_STATUS_RESET[USEL_BIT_RX_SVC],
             rx_idle: USEL_STATUS_RESET[USEL_BIT_RX_IDLE], brk_begin: USEL_STATUS_RESET[USEL_BIT_BRK_BEGIN],
             brk_end: USEL_STATUS_RESET[USEL_BIT_BRK_END], fifo_err: USEL_STATUS_RESET[USEL_BIT_FIFO_ERR],
             tx_ie: USEL_CONTROL_RESET[USEL_BIT_TX_IE], rx_ie: USEL_CONTROL_RESET[USEL_BIT_RX_IE],
             brk: USEL_BRK_OPEN, line_prev: 1'b1,
             tx_dma: 1'b0, rx_dma: 1'b0, irq: 1'b0, store: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign awready_out     = s.awready;
  assign wready_out      = s.wready;
  assign bvalid_out      = s.bvalid;
  assign bresp_out       = s.bresp;
  assign arready_out     = s.arready;
  assign rvalid_out      = s.rvalid;
  assign rresp_out       = s.rresp;
  assign rdata_out       = s.rdata;
  assign tx_dma_req_out  = s.tx_dma;
  assign rx_dma_req_out  = s.rx_dma;
  assign irq_out         = s.irq;
  assign frame_store_out = s.store;

  a_irq_tracks_bits: assert property (@(posedge clock_in) disable iff (!rst_n)
    irq_out == ((s.tx_flag && s.tx_ie) || (s.rx_flag && s.rx_ie) || (s.rx_idle && s.rx_ie)
                || s.brk_begin || s.brk_end || s.fifo_err))
    else $error("Interrupt does not follow status bits");

  a_w1c_zero_keeps: assert property (@(posedge clock_in) disable iff (!rst_n)
    (do_write && s.brk_begin && !stat_w1c[USEL_BIT_BRK_BEGIN]) |=> s.brk_begin)
    else $error("Writing zero cleared break begin");

  a_w1c_one_clears: assert property (@(posedge clock_in) disable iff (!rst_n)
    (stat_w1c[USEL_BIT_BRK_END] && !(s.brk == USEL_BRK_LOCKED && line_rise && receiver_enable_in))
    |=> !s.brk_end)
    else $error("Writing one did not clear break end");

  a_tx_flag_level: assert property (@(posedge clock_in) disable iff (!rst_n)
    ##1 s.tx_flag == $past(transmitter_enable_in && tx_fifo_level_in <= 4'h4))
    else $error("Transmit flag wrong for fill level");

  a_rx_flag_level: assert property (@(posedge clock_in) disable iff (!rst_n)
    ##1 s.rx_flag == $past(receiver_enable_in && rx_fifo_level_in >= 4'h8))
    else $error("Receive flag wrong for fill level");

  a_tx_dma_req: assert property (@(posedge clock_in) disable iff (!rst_n)
    tx_dma_req_out == s.tx_flag)
    else $error("Transmit DMA request not tied to flag");

  a_rx_dma_req: assert property (@(posedge clock_in) disable iff (!rst_n)
    rx_dma_req_out == (s.rx_flag && !s.fifo_err))
    else $error("Receive DMA request wrong");

  a_idle_sets: assert property (@(posedge clock_in) disable iff (!rst_n)
    idle_pulse |=> s.rx_idle)
    else $error("Idle pulse did not set idle status");

  a_begin_needs_open: assert property (@(posedge clock_in) disable iff (!rst_n)
    $rose(s.brk_begin) |-> $past(s.brk) == USEL_BRK_OPEN && s.brk == USEL_BRK_LOCKED)
    else $error("Break begin set while interlocked");

  a_null_discard: assert property (@(posedge clock_in) disable iff (!rst_n)
    (null_fe && s.brk == USEL_BRK_LOCKED) |=> !frame_store_out)
    else $error("Repeated null frame was stored");

  a_end_on_rise: assert property (@(posedge clock_in) disable iff (!rst_n)
    $rose(s.brk_end) |-> $past(s.brk) == USEL_BRK_LOCKED && s.brk == USEL_BRK_OPEN)
    else $error("Break end without interlock");

endmodule // usel_top
`default_nettype wire

// ### testbench/usel_intc_model.sv
// Interrupt controller model that gates the port interrupt
`timescale 1ns/1ps
`default_nettype none
module usel_intc_model (
  input  wire logic        port_irq_in,
  input  wire logic [31:0] mask_in,
  output var  logic        cpu_irq_out
);
  // One mask bit, bit 17, passes the serial port interrupt request when set and blocks it when clear; the DMA requests do not pass through this model
  always_comb cpu_irq_out = port_irq_in & mask_in[17];
endmodule // usel_intc_model
`default_nettype wire

// ### testbench/test_uart_status_event_logic.sv
// Bench for the serial port status and event logic
`timescale 1ns/1ps
`default_nettype none
module test_uart_status_event_logic
  import usel_pkg::*;
;
  localparam logic [31:0] M_TS = 32'h1 << USEL_BIT_TX_SVC;
  localparam logic [31:0] M_RS = 32'h1 << USEL_BIT_RX_SVC;
  localparam logic [31:0] M_ID = 32'h1 << USEL_BIT_RX_IDLE;
  localparam logic [31:0] M_BB = 32'h1 << USEL_BIT_BRK_BEGIN;
  localparam logic [31:0] M_BE = 32'h1 << USEL_BIT_BRK_END;
  localparam logic [31:0] M_FE = 32'h1 << USEL_BIT_FIFO_ERR;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        tx_en = 0, rx_en = 0, pin = 1, fdone = 0, fnull = 0, ferr = 0, ftick = 0, tail = 0;
  logic [3:0]  awaddr = 0, araddr = 0, tx_lvl = 0, rx_lvl = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0, mask = 0, stores = 0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, tx_dma, rx_dma, irq, store, cpu_irq;
  logic [1:0]  bresp, rresp;
  int          error_cnt = 0, n_checks = 0;

  usel_top dut (.clock_in(clk), .rst_n_in(rst_n), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .tx_fifo_level_in(tx_lvl), .rx_fifo_level_in(rx_lvl), .transmitter_enable_in(tx_en),
    .receiver_enable_in(rx_en), .rx_pin_in(pin), .frame_done_in(fdone), .frame_null_in(fnull),
    .frame_framing_err_in(ferr), .frame_tick_in(ftick), .rx_tail_error_in(tail),
    .tx_dma_req_out(tx_dma), .rx_dma_req_out(rx_dma), .irq_out(irq), .frame_store_out(store));

  usel_intc_model intc (.port_irq_in(irq), .mask_in(mask), .cpu_irq_out(cpu_irq));

  always #2.5 clk = ~clk;

  // Store pulses last one cycle, so sample them away from the launching edge
  always @(negedge clk) if (store === 1'b1) stores <= stores + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready flags are registered, so the value seen mid-cycle is what the next edge samples
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, done;
    logic [1:0] r;
    int n;
    done = 0;
    r = 2'bxx;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      ad = awvalid & awready;
      wd = wvalid & wready;
      if (bvalid === 1'b1) begin
        done = 1;
        r = bresp;
      end
      @(posedge clk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    // Step off the edge so callers never sample outputs as they launch
    #1;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    done = 0;
    d = 'x;
    r = 2'bxx;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      ah = arvalid & arready;
      if (rvalid === 1'b1) begin
        done = 1;
        d = rdata;
        r = rresp;
      end
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    #1;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic w3();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // DMA servicer drains one burst of four words per pending request
  task automatic svc_burst();
    @(posedge clk);
    if (rx_dma === 1'b1) rx_lvl <= rx_lvl - 4'h4;
    w3();
  endtask

  task automatic frame(input logic nl, input logic fe);
    @(posedge clk);
    fdone <= 1'b1;
    fnull <= nl;
    ferr <= fe;
    @(posedge clk);
    fdone <= 1'b0;
    fnull <= 1'b0;
    ferr <= 1'b0;
    w3();
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      ftick <= 1'b1;
      @(posedge clk);
      ftick <= 1'b0;
    end
    w3();
  endtask

  // Pin low long enough to pass the filter, then a rising edge
  task automatic rise();
    @(posedge clk);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    pin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [31:0] s0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    rd(USEL_CONTROL_OFF, 32'h0, USEL_RESP_OKAY);
    rd(4'h8, 32'h0, USEL_RESP_SLVERR);
    wr(4'h8, 32'h3, USEL_RESP_SLVERR);
    @(posedge clk);
    tx_en <= 1'b1;
    tx_lvl <= 4'h4;
    w3();
    chk(tx_dma, 32'h1);
    chk(irq, 32'h0);
    wr(USEL_CONTROL_OFF, 32'h1, USEL_RESP_OKAY);
    w3();
    chk(irq, 32'h1);
    chk(cpu_irq, 32'h0);
    mask <= 32'h1 << 17;
    w3();
    chk(cpu_irq, 32'h1);
    wr(USEL_STATUS_OFF, 32'hff, USEL_RESP_OKAY);
    rd(USEL_STATUS_OFF, M_TS, USEL_RESP_OKAY);
    @(posedge clk);
    tx_lvl <= 4'h5;
    w3();
    chk(tx_dma, 32'h0);
    chk(irq, 32'h0);
    @(posedge clk);
    rx_en <= 1'b1;
    rx_lvl <= 4'h7;
    w3();
    chk(rx_dma, 32'h0);
    @(posedge clk);
    rx_lvl <= 4'h8;
    w3();
    chk(rx_dma, 32'h1);
    chk(irq, 32'h0);
    wr(USEL_CONTROL_OFF, 32'h2, USEL_RESP_OKAY);
    rd(USEL_STATUS_OFF, M_RS, USEL_RESP_OKAY);
    chk(irq, 32'h1);
    @(posedge clk);
    tail <= 1'b1;
    w3();
    chk(rx_dma, 32'h0);
    wr(USEL_CONTROL_OFF, 32'h0, USEL_RESP_OKAY);
    rd(USEL_STATUS_OFF, M_RS | M_FE, USEL_RESP_OKAY);
    chk(irq, 32'h1);
    @(posedge clk);
    tail <= 1'b0;
    rx_lvl <= 4'h7;
    w3();
    chk(rx_dma, 32'h0);
    chk(irq, 32'h0);
    @(posedge clk);
    rx_lvl <= 4'hc;
    w3();
    chk(rx_dma, 32'h1);
    svc_burst();
    chk(rx_dma, 32'h1);
    svc_burst();
    chk(rx_dma, 32'h0);
    @(posedge clk);
    rx_lvl <= 4'h1;
    tick(2);
    rd(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    tick(1);
    rd(USEL_STATUS_OFF, M_ID, USEL_RESP_OKAY);
    chk(irq, 32'h0);
    wr(USEL_CONTROL_OFF, 32'h2, USEL_RESP_OKAY);
    w3();
    chk(irq, 32'h1);
    wr(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    rd(USEL_STATUS_OFF, M_ID, USEL_RESP_OKAY);
    wr(USEL_STATUS_OFF, M_ID, USEL_RESP_OKAY);
    w3();
    chk(irq, 32'h0);
    wr(USEL_CONTROL_OFF, 32'h0, USEL_RESP_OKAY);
    s0 = stores;
    frame(1'b1, 1'b1);
    chk(stores, s0 + 1);
    rd(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    chk(irq, 32'h1);
    wr(USEL_STATUS_OFF, M_ID | M_BE, USEL_RESP_OKAY);
    rd(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    frame(1'b1, 1'b1);
    chk(stores, s0 + 1);
    frame(1'b0, 1'b0);
    chk(stores, s0 + 2);
    wr(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    frame(1'b1, 1'b1);
    rd(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    rise();
    rd(USEL_STATUS_OFF, M_BE, USEL_RESP_OKAY);
    chk(irq, 32'h1);
    wr(USEL_STATUS_OFF, M_BE, USEL_RESP_OKAY);
    rise();
    rd(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    frame(1'b1, 1'b1);
    chk(stores, s0 + 3);
    rd(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    @(posedge clk);
    rx_en <= 1'b0;
    w3();
    @(posedge clk);
    rx_en <= 1'b1;
    wr(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    rise();
    rd(USEL_STATUS_OFF, 32'h0, USEL_RESP_OKAY);
    frame(1'b1, 1'b1);
    chk(stores, s0 + 4);
    rd(USEL_STATUS_OFF, M_BB, USEL_RESP_OKAY);
    wrap_up();
  end
endmodule // test_uart_status_event_logic
`default_nettype wire
